//--- src/seq_ram_pkg.sv
package seq_ram_pkg;
   // Array geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CMD_W = 12;
   localparam int CMD_SEL_W = 3;

   // Command register selection codes on the low address bits
   localparam logic [2:0] CMD_START_ONE = 3'h0;
   localparam logic [2:0] CMD_END_ONE = 3'h1;
   localparam logic [2:0] CMD_START_TWO = 3'h2;
   localparam logic [2:0] CMD_END_TWO = 3'h3;
   localparam logic [2:0] CMD_FLOW = 3'h4;
   localparam logic [2:0] CMD_FLAGS = 3'h5;

   // Fixed upper bits shown when a command register is read
   localparam logic [3:0] CMD_READ_TOP = 4'hE;

   // Bit positions in the flag clear word and the flag status word
   localparam int FLAG_ONE_BIT = 0;
   localparam int FLAG_TWO_BIT = 1;

   // Reset values
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [11:0] START_ONE_RESET = 12'h000;
   localparam logic [11:0] END_ONE_RESET = 12'hFFF;
   localparam logic [11:0] START_TWO_RESET = 12'h000;
   localparam logic [11:0] END_TWO_RESET = 12'h000;
   localparam logic [11:0] FLOW_RESET = 12'h000;
   localparam logic FLAG_RESET_N = 1'b1;
endpackage

//--- src/ram_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ram_port_if;
   logic [11:0] rnd_addr;
   logic [1:0] rnd_byte_we;
   logic [15:0] rnd_wdata;
   logic [15:0] rnd_rdata;
   logic [11:0] seq_addr;
   logic seq_we;
   logic [15:0] seq_wdata;
   logic [15:0] seq_rdata;

   modport ctrl (
      output rnd_addr, rnd_byte_we, rnd_wdata, seq_addr, seq_we, seq_wdata,
      input rnd_rdata, seq_rdata
   );
   modport mem (
      input rnd_addr, rnd_byte_we, rnd_wdata, seq_addr, seq_we, seq_wdata,
      output rnd_rdata, seq_rdata
   );
endinterface
`default_nettype wire

//--- src/dual_port_array.sv
`timescale 1ns/10ps
`default_nettype none
module dual_port_array #(
   parameter int DEPTH = 4096
) (
   input wire logic clk,
   ram_port_if.mem ports
);
   logic [15:0] mem_r [DEPTH];

   // Both ports write and read on the same edge; sequential write lands last
   always_ff @(posedge clk) begin
      for (int b = 0; b < 2; b++) begin
         if (ports.rnd_byte_we[b]) begin
            mem_r[ports.rnd_addr][b*seq_ram_pkg::BYTE_W +: seq_ram_pkg::BYTE_W] <=
               ports.rnd_wdata[b*seq_ram_pkg::BYTE_W +: seq_ram_pkg::BYTE_W];
         end
      end
      if (ports.seq_we) begin
         mem_r[ports.seq_addr] <= ports.seq_wdata;
      end
      ports.rnd_rdata <= mem_r[ports.rnd_addr];
      ports.seq_rdata <= mem_r[ports.seq_addr];
   end
endmodule
`default_nettype wire

//--- src/dual_port_sequential_ram_ports.sv
// Summary of operation
// R1 - Random read drives stored data only on lanes whose byte enable is low.
// R2 - Random write stores only lanes whose byte enable is low.
// R3 - Chip and command select both inactive: lanes float, power-down asserted.
// R4 - Selected read with output enable inactive floats lanes, stays powered.
// R5 - Both byte enables high: no array access, lanes float, powered up.
// R6 - Command write loads low twelve bits into addressed command register.
// R7 - Command read drives addressed command register onto random data lines.
// R8 - Command accesses honour each byte enable separately.
// R9 - Random port ignores every sequential port input.
// R10 - Sequential read outputs word at pointer; no advance with count enable high.
// R11 - Count enable low on read advances pointer, end flag low at end address.
// R12 - End flags hold their level when their end address is not reached.
// R13 - Sequential output enable high floats bus; pointer and flags still update.
// R14 - Sequential write captures all sixteen bits at pointer; no advance if disabled.
// R15 - Count enable low on write advances pointer and sets reached end flags.
// R16 - Deselected: no access, bus floats, pointer advances only with count enable.
// R17 - A sequential write ends at any edge sampling direction or select high.
// R18 - With count enable low the address increments before that cycle's access.
// R19 - Master keeps pointer load and start jumps high during plain accesses.
// R20 - Host avoids command mode while the sequential port runs.
// R21 - Master raises sequential output enable before a write following a read.
// R22 - Sequential port ignores all random port pins except command select.
// R23 - Pointer and random address are twelve bits over the shared array.
`timescale 1ns/10ps
`default_nettype none
module dual_port_sequential_ram_ports #(
   parameter int DEPTH = 4096
) (
   input wire logic clk,
   input wire logic rst,
   // Random access port
   input wire logic chip_select_n,
   input wire logic cmd_select_n,
   input wire logic read_not_write,
   input wire logic output_enable_n,
   input wire logic lower_byte_enable_n,
   input wire logic upper_byte_enable_n,
   input wire logic [11:0] rnd_addr,
   input wire logic [15:0] rnd_data_in,
   output logic [15:0] rnd_data_out,
   output logic rnd_data_oe_lo,
   output logic rnd_data_oe_hi,
   output logic power_down,
   // Sequential port
   input wire logic seq_port_select_n,
   input wire logic seq_count_enable_n,
   input wire logic seq_read_not_write,
   input wire logic seq_output_enable_n,
   input wire logic pointer_load_n,
   input wire logic jump_to_buffer_one_start_n,
   input wire logic jump_to_buffer_two_start_n,
   input wire logic [15:0] seq_data_in,
   output logic [15:0] seq_data_out,
   output logic seq_data_oe,
   output logic buffer_one_end_flag_n,
   output logic buffer_two_end_flag_n,
   output logic [11:0] seq_pointer
);
   ram_port_if ports ();

   dual_port_array #(
      .DEPTH(DEPTH)
   ) u_array (
      .clk(clk),
      .ports(ports)
   );

   // Merge a write word into a command register, one byte lane at a time
   function automatic logic [11:0] merge_cmd(
      input logic [11:0] old_val,
      input logic [15:0] wdata,
      input logic lo_n,
      input logic hi_n
   );
      logic [11:0] res;
      res = old_val;
      if (!lo_n) begin
         res[7:0] = wdata[7:0];
      end
      if (!hi_n) begin
         res[11:8] = wdata[11:8];
      end
      return res;
   endfunction

   // Command register file
   logic [11:0] start_one_r;
   logic [11:0] end_one_r;
   logic [11:0] start_two_r;
   logic [11:0] end_two_r;
   logic [11:0] flow_r;
   logic flag_one_n_r;
   logic flag_two_n_r;

   // Sequential state
   logic [11:0] ptr_r;
   logic [11:0] load_data_r;
   logic load_pending_r;
   logic seq_read_r;

   // Random read state
   logic rnd_cmd_read_r;
   logic [15:0] cmd_rdata_r;

   // Random port mode decode
   wire array_sel = !chip_select_n && cmd_select_n;
   wire cmd_sel = chip_select_n && !cmd_select_n;
   wire any_byte = !lower_byte_enable_n || !upper_byte_enable_n;
   wire array_write = array_sel && !read_not_write && any_byte;
   wire cmd_write = cmd_sel && !read_not_write && any_byte;
   wire cmd_read = cmd_sel && read_not_write;
   wire lane_read = (array_sel || cmd_sel) && read_not_write && !output_enable_n;
   wire [2:0] cmd_code = rnd_addr[2:0];

   // Random port drives only the enabled lanes of a read
   assign rnd_data_oe_lo = lane_read && !lower_byte_enable_n; // R1 R4 R5 R7 R8
   assign rnd_data_oe_hi = lane_read && !upper_byte_enable_n; // R1 R4 R5 R7 R8
   assign power_down = chip_select_n && cmd_select_n; // R3

   // Random array access uses only random port pins
   assign ports.rnd_addr = rnd_addr; // R9 R23
   assign ports.rnd_wdata = rnd_data_in;
   assign ports.rnd_byte_we = {array_write && !upper_byte_enable_n,
                               array_write && !lower_byte_enable_n}; // R2 R5 R9

   // Command register read value
   logic [11:0] cmd_view;
   always_comb begin
      cmd_view = 12'h000;
      unique case (cmd_code)
         seq_ram_pkg::CMD_START_ONE: cmd_view = start_one_r;
         seq_ram_pkg::CMD_END_ONE: cmd_view = end_one_r;
         seq_ram_pkg::CMD_START_TWO: cmd_view = start_two_r;
         seq_ram_pkg::CMD_END_TWO: cmd_view = end_two_r;
         seq_ram_pkg::CMD_FLOW: cmd_view = flow_r;
         seq_ram_pkg::CMD_FLAGS: begin
            cmd_view[seq_ram_pkg::FLAG_ONE_BIT] = flag_one_n_r;
            cmd_view[seq_ram_pkg::FLAG_TWO_BIT] = flag_two_n_r;
         end
         default: cmd_view = 12'h000;
      endcase
   end
   wire [15:0] cmd_word = {seq_ram_pkg::CMD_READ_TOP, cmd_view}; // R7

   // Capture what the random port is reading
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rnd_cmd_read_r <= 1'b0;
         cmd_rdata_r <= 16'h0000;
      end else begin
         rnd_cmd_read_r <= cmd_read;
         cmd_rdata_r <= cmd_word;
      end
   end

   // Random read data: command view or stored word
   assign rnd_data_out = rnd_cmd_read_r ? cmd_rdata_r : ports.rnd_rdata; // R1 R7

   // Sequential pointer decode; random pins other than command select unused
   wire seq_sel = !seq_port_select_n; // R22
   wire seq_write = seq_sel && !seq_read_not_write; // R17
   wire seq_read = seq_sel && seq_read_not_write;
   wire jump_one = !jump_to_buffer_one_start_n;
   wire jump_two = !jump_to_buffer_two_start_n;
   wire do_load = !pointer_load_n;
   wire hold_ptr = load_pending_r || do_load;
   wire advance = !seq_count_enable_n && !hold_ptr && !jump_one && !jump_two; // R10 R14 R16
   wire [11:0] ptr_inc = ptr_r + 12'h001;

   // Address used this edge: incremented before the access when counting
   logic [11:0] seq_addr;
   always_comb begin
      seq_addr = ptr_r;
      if (load_pending_r) begin
         seq_addr = load_data_r;
      end else if (jump_one) begin
         seq_addr = start_one_r;
      end else if (jump_two) begin
         seq_addr = start_two_r;
      end else if (advance) begin
         seq_addr = ptr_inc; // R11 R15 R18
      end
   end

   // Sequential array access
   assign ports.seq_addr = seq_addr; // R23
   assign ports.seq_wdata = seq_data_in; // R14
   assign ports.seq_we = seq_write && !do_load; // R14 R16 R17 R19

   // End of buffer detection on the advanced address
   wire hit_one = advance && (seq_addr == end_one_r); // R11 R15
   wire hit_two = advance && (seq_addr == end_two_r); // R11 R15

   // Flag clear from the command port
   wire flag_clear = cmd_write && (cmd_code == seq_ram_pkg::CMD_FLAGS);
   wire clr_one = flag_clear && !lower_byte_enable_n && rnd_data_in[seq_ram_pkg::FLAG_ONE_BIT];
   wire clr_two = flag_clear && !lower_byte_enable_n && rnd_data_in[seq_ram_pkg::FLAG_TWO_BIT];

   // End flags: reaching the end wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_one_n_r <= seq_ram_pkg::FLAG_RESET_N;
         flag_two_n_r <= seq_ram_pkg::FLAG_RESET_N;
      end else begin
         if (hit_one) begin
            flag_one_n_r <= 1'b0; // R11 R15 R16
         end else if (clr_one) begin
            flag_one_n_r <= 1'b1;
         end
         if (hit_two) begin
            flag_two_n_r <= 1'b0; // R11 R15 R16
         end else if (clr_two) begin
            flag_two_n_r <= 1'b1;
         end
      end
   end
   assign buffer_one_end_flag_n = flag_one_n_r; // R12
   assign buffer_two_end_flag_n = flag_two_n_r; // R12

   // Pointer, pending load and read tracking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_r <= seq_ram_pkg::PTR_RESET;
         load_data_r <= seq_ram_pkg::PTR_RESET;
         load_pending_r <= 1'b0;
         seq_read_r <= 1'b0;
      end else begin
         ptr_r <= seq_addr; // R10 R13 R16
         load_pending_r <= do_load && !load_pending_r;
         if (do_load && !load_pending_r) begin
            load_data_r <= seq_data_in[11:0];
         end
         seq_read_r <= seq_read && !do_load; // R10 R17
      end
   end
   assign seq_pointer = ptr_r;

   // Sequential bus drives read data only while enabled
   assign seq_data_out = ports.seq_rdata; // R10
   assign seq_data_oe = seq_read_r && !seq_output_enable_n; // R13 R16 R21

   // Command register writes, each byte lane on its own
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_one_r <= seq_ram_pkg::START_ONE_RESET;
         end_one_r <= seq_ram_pkg::END_ONE_RESET;
         start_two_r <= seq_ram_pkg::START_TWO_RESET;
         end_two_r <= seq_ram_pkg::END_TWO_RESET;
         flow_r <= seq_ram_pkg::FLOW_RESET;
      end else if (cmd_write) begin // R6 R20
         unique case (cmd_code)
            seq_ram_pkg::CMD_START_ONE:
               start_one_r <= merge_cmd(start_one_r, rnd_data_in, lower_byte_enable_n, upper_byte_enable_n); // R8
            seq_ram_pkg::CMD_END_ONE:
               end_one_r <= merge_cmd(end_one_r, rnd_data_in, lower_byte_enable_n, upper_byte_enable_n); // R8
            seq_ram_pkg::CMD_START_TWO:
               start_two_r <= merge_cmd(start_two_r, rnd_data_in, lower_byte_enable_n, upper_byte_enable_n); // R8
            seq_ram_pkg::CMD_END_TWO:
               end_two_r <= merge_cmd(end_two_r, rnd_data_in, lower_byte_enable_n, upper_byte_enable_n); // R8
            seq_ram_pkg::CMD_FLOW:
               flow_r <= merge_cmd(flow_r, rnd_data_in, lower_byte_enable_n, upper_byte_enable_n); // R8
            default: begin
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- bench/seq_ram_properties.sv
`timescale 1ns/10ps
`default_nettype none
module seq_ram_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic cmd_select_n,
   input wire logic read_not_write,
   input wire logic output_enable_n,
   input wire logic lower_byte_enable_n,
   input wire logic upper_byte_enable_n,
   input wire logic [15:0] rnd_data_out,
   input wire logic rnd_data_oe_lo,
   input wire logic rnd_data_oe_hi,
   input wire logic power_down,
   input wire logic seq_port_select_n,
   input wire logic seq_count_enable_n,
   input wire logic seq_read_not_write,
   input wire logic seq_output_enable_n,
   input wire logic pointer_load_n,
   input wire logic jump_to_buffer_one_start_n,
   input wire logic jump_to_buffer_two_start_n,
   input wire logic seq_data_oe,
   input wire logic buffer_one_end_flag_n,
   input wire logic buffer_two_end_flag_n,
   input wire logic [11:0] seq_pointer
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Two edges with no load, jump or pending load
   sequence s_quiet;
      pointer_load_n && jump_to_buffer_one_start_n && jump_to_buffer_two_start_n;
   endsequence
   sequence s_calm;
      s_quiet ##1 s_quiet;
   endsequence
   // Random port lanes and power
   property p_pd; power_down == (chip_select_n && cmd_select_n); endproperty
   property p_lo; rnd_data_oe_lo |-> !lower_byte_enable_n && !output_enable_n && read_not_write; endproperty
   property p_hi; rnd_data_oe_hi |-> !upper_byte_enable_n && !output_enable_n && read_not_write; endproperty
   property p_cmd;
      chip_select_n && !cmd_select_n && read_not_write && !output_enable_n
         |=> rnd_data_out[15:12] == seq_ram_pkg::CMD_READ_TOP;
   endproperty
   // Sequential port bus, pointer and flags
   property p_soe; seq_output_enable_n |-> !seq_data_oe; endproperty
   property p_sdo; seq_data_oe |-> !$past(seq_port_select_n) && $past(seq_read_not_write); endproperty
   property p_hold; s_calm ##0 seq_count_enable_n |=> $stable(seq_pointer); endproperty
   property p_adv; s_calm ##0 !seq_count_enable_n |=> seq_pointer == $past(seq_pointer) + 12'h001; endproperty
   property p_eob;
      $fell(buffer_one_end_flag_n) || $fell(buffer_two_end_flag_n) |-> !$past(seq_count_enable_n);
   endproperty
   a_pd: assert property (p_pd) else $error("power down wrong");
   a_lo: assert property (p_lo) else $error("low lane driven wrongly");
   a_hi: assert property (p_hi) else $error("high lane driven wrongly");
   a_cmd: assert property (p_cmd) else $error("command read top bits wrong");
   a_soe: assert property (p_soe) else $error("sequential bus driven while disabled");
   a_sdo: assert property (p_sdo) else $error("sequential bus driven without read");
   a_hold: assert property (p_hold) else $error("pointer moved without count");
   a_adv: assert property (p_adv) else $error("pointer did not advance by one");
   a_eob: assert property (p_eob) else $error("end flag fell without advance");
endmodule
`default_nettype wire

//--- bench/seq_master.sv
`timescale 1ns/10ps
`default_nettype none
module seq_master (
   input wire logic clk,
   output logic seq_port_select_n,
   output logic seq_count_enable_n,
   output logic seq_read_not_write,
   output logic seq_output_enable_n,
   output logic pointer_load_n,
   output logic jump_to_buffer_one_start_n,
   output logic jump_to_buffer_two_start_n,
   output logic [15:0] seq_data_in
);
   // Park deselected with load and jumps high
   initial begin
      {seq_port_select_n, seq_count_enable_n, seq_read_not_write, seq_output_enable_n} = 4'hF;
      {pointer_load_n, jump_to_buffer_one_start_n, jump_to_buffer_two_start_n} = 3'h7;
      seq_data_in = 16'h0000;
   end
   // One access edge, then idle; a released bus shows the inverse
   task op(input logic s, input logic c, input logic r, input logic o, input logic [15:0] d);
      @(posedge clk);
      seq_port_select_n <= s;
      seq_count_enable_n <= c;
      seq_read_not_write <= r;
      seq_output_enable_n <= r ? o : 1'b1;
      seq_data_in <= r ? ~seq_data_in : d;
      @(posedge clk);
      seq_port_select_n <= 1'b1;
      seq_count_enable_n <= 1'b1;
      seq_data_in <= ~seq_data_in;
      #1;
   endtask
   // Pointer load: capture edge then idle edge
   task ld(input logic [11:0] a);
      @(posedge clk);
      pointer_load_n <= 1'b0;
      seq_data_in <= {4'h0, a};
      @(posedge clk);
      pointer_load_n <= 1'b1;
      seq_data_in <= ~{4'h0, a};
   endtask
   // Jump to the first buffer start, or the second with two high, for one edge
   task jump(input logic two);
      @(posedge clk);
      jump_to_buffer_one_start_n <= two;
      jump_to_buffer_two_start_n <= !two;
      @(posedge clk);
      jump_to_buffer_one_start_n <= 1'b1;
      jump_to_buffer_two_start_n <= 1'b1;
      #1;
   endtask
endmodule
`default_nettype wire

//--- bench/dual_port_sequential_ram_ports_test.sv
`timescale 1ns/10ps
`default_nettype none
module dual_port_sequential_ram_ports_test;
   logic clk, rst, chip_select_n, cmd_select_n, read_not_write, output_enable_n;
   logic lower_byte_enable_n, upper_byte_enable_n, rnd_data_oe_lo, rnd_data_oe_hi, power_down;
   logic [11:0] rnd_addr, seq_pointer, p_m, a;
   logic [15:0] rnd_data_in, rnd_data_out, seq_data_in, seq_data_out, want, d2;
   logic seq_data_oe, buffer_one_end_flag_n, buffer_two_end_flag_n, f1, f2, lo_s, hi_s, pd_s;
   logic seq_port_select_n, seq_count_enable_n, seq_read_not_write, seq_output_enable_n;
   logic pointer_load_n, jump_to_buffer_one_start_n, jump_to_buffer_two_start_n;
   logic [15:0] mem_m [0:4095];
   logic [1:0] be;
   logic [5:0] md [3] = '{6'h30, 6'h1C, 6'h1B};
   int error_cnt = 0;
   int tests_run = 0;
   int seed = 51139;
   int k;
   dual_port_sequential_ram_ports u_dut (.*);
   seq_master u_sm (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Expected merge and lane mask, be = {lower, upper} enables
   function logic [15:0] mrg(input logic [15:0] o, input logic [15:0] n, input logic [1:0] b);
      mrg = {b[0] ? o[15:8] : n[15:8], b[1] ? o[7:0] : n[7:0]};
   endfunction
   function logic [15:0] lmask(input logic [1:0] b);
      lmask = {{8{!b[0]}}, {8{!b[1]}}};
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] exp_v);
      tests_run++;
      if (got !== exp_v) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp_v);
         error_cnt++;
      end
   endtask
   // Random port cycle: {cs, cmd, rnw, oe, lb, ub}; enables sampled, then idle
   task rw(input logic [5:0] c, input logic [11:0] ad, input logic [15:0] d);
      @(posedge clk);
      {chip_select_n, cmd_select_n, read_not_write, output_enable_n, lower_byte_enable_n, upper_byte_enable_n} <= c;
      rnd_addr <= ad;
      rnd_data_in <= d;
      #1;
      {lo_s, hi_s, pd_s} = {rnd_data_oe_lo, rnd_data_oe_hi, power_down};
      @(posedge clk);
      {chip_select_n, cmd_select_n} <= 2'h3;
      #1;
   endtask
   // Pointer model step
   task adv(input logic c);
      if (!c) begin
         p_m++;
         f1 = (p_m == 12'h010) ? 1'b0 : f1;
         f2 = (p_m == 12'h00E) ? 1'b0 : f2;
      end
   endtask
   task test_done;
      $display("checks=%0d errors=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Whole run is under two hundred cycles
   initial begin
      #100000;
      error_cnt++;
      test_done;
   end
   initial begin
      rst = 1'b1;
      {chip_select_n, cmd_select_n, read_not_write, output_enable_n} = 4'hF;
      {lower_byte_enable_n, upper_byte_enable_n, rnd_addr, rnd_data_in} = '1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // Byte lane writes and reads
      for (k = 0; k < 6; k++) begin
         a = 12'($random(seed));
         want = 16'($random(seed));
         d2 = 16'($random(seed));
         be = 2'(k % 3);
         rw(6'h14, a, want);
         rw(6'h14 | {4'h0, be}, a, d2);
         mem_m[a] = mrg(want, d2, be);
         rw(6'h18 | {4'h0, be}, a, 16'h0000);
         chk(16'({lo_s, hi_s}), 16'({!be[1], !be[0]}));
         chk(rnd_data_out & lmask(be), mem_m[a] & lmask(be));
      end
      // Deselect, output disable, both lanes off
      for (k = 0; k < 3; k++) begin
         rw(md[k], a, 16'h0000);
         chk(16'({lo_s, hi_s, pd_s}), (k == 0) ? 16'h0001 : 16'h0000);
      end
      rw(6'h17, a, ~mem_m[a]);
      rw(6'h18, a, 16'h0000);
      chk(rnd_data_out, mem_m[a]);
      // Command register codes 0 to 4 (not the flags code), then a lower byte only write
      for (k = 0; k < 5; k++) begin
         want = 16'($random(seed));
         rw(6'h24, {9'($random(seed)), 3'(k)}, want);
         rw(6'h28, {9'h000, 3'(k)}, 16'h0000);
         chk(rnd_data_out, {seq_ram_pkg::CMD_READ_TOP, want[11:0]});
      end
      d2 = 16'($random(seed));
      rw(6'h25, {9'h000, seq_ram_pkg::CMD_FLOW}, d2);
      rw(6'h28, {9'h000, seq_ram_pkg::CMD_FLOW}, 16'h0000);
      chk(rnd_data_out, {seq_ram_pkg::CMD_READ_TOP, want[11:8], d2[7:0]});
      rw(6'h24, {9'h000, seq_ram_pkg::CMD_START_ONE}, 16'h000C);
      rw(6'h24, {9'h000, seq_ram_pkg::CMD_END_ONE}, 16'h0010);
      rw(6'h24, {9'h000, seq_ram_pkg::CMD_END_TWO}, 16'h000E);
      // Sequential writes, alternating count enable
      u_sm.ld(12'h00C);
      {p_m, f1, f2} = {12'h00C, 2'h3};
      for (k = 0; k < 8; k++) begin
         want = 16'($random(seed));
         u_sm.op(1'b0, !k[0], 1'b0, 1'b1, want);
         adv(!k[0]);
         mem_m[p_m] = want;
         chk(16'(seq_pointer), 16'(p_m));
         chk(16'({buffer_one_end_flag_n, buffer_two_end_flag_n}), 16'({f1, f2}));
      end
      u_sm.op(1'b1, 1'b0, 1'b0, 1'b1, 16'h0000);
      adv(1'b0);
      chk(16'({seq_data_oe, seq_pointer}), 16'(p_m));
      u_sm.jump(1'b0);
      p_m = 12'h00C;
      // Sequential reads back over the written words
      for (k = 0; k < 8; k++) begin
         u_sm.op(1'b0, !k[0], 1'b1, 1'b0, 16'h0000);
         adv(!k[0]);
         chk(seq_data_out, mem_m[p_m]);
         chk(16'({seq_data_oe, seq_pointer}), {4'h1, p_m});
         chk(16'({buffer_one_end_flag_n, buffer_two_end_flag_n}), 16'({f1, f2}));
      end
      u_sm.op(1'b0, 1'b0, 1'b1, 1'b1, 16'h0000);
      adv(1'b0);
      chk(16'({seq_data_oe, seq_pointer}), 16'(p_m));
      u_sm.op(1'b1, 1'b1, 1'b1, 1'b0, 16'h0000);
      chk(16'({seq_data_oe, seq_pointer}), 16'(p_m));
      // Flag status and clear while the sequential port idles
      rw(6'h28, {9'h000, seq_ram_pkg::CMD_FLAGS}, 16'h0000);
      chk(16'(rnd_data_out[1:0]), 16'h0000);
      rw(6'h24, {9'h000, seq_ram_pkg::CMD_FLAGS}, 16'h0003);
      rw(6'h28, {9'h000, seq_ram_pkg::CMD_FLAGS}, 16'h0000);
      chk(16'({rnd_data_out[1:0], buffer_one_end_flag_n, buffer_two_end_flag_n}), 16'h000F);
      // Reserved code reads zero; second buffer start reached by a jump
      rw(6'h28, {9'h000, 3'h6}, 16'h0000);
      chk(rnd_data_out, {seq_ram_pkg::CMD_READ_TOP, 12'h000});
      rw(6'h24, {9'h000, seq_ram_pkg::CMD_START_TWO}, 16'h0ABC);
      u_sm.jump(1'b1);
      chk(16'(seq_pointer), 16'h0ABC);
      test_done;
   end
endmodule
bind dual_port_sequential_ram_ports seq_ram_properties u_props (.*);
`default_nettype wire
